/* File: design/difl_drive_input_function_logic.sv */
`timescale 1ns/1ps
module difl_drive_input_function_logic #(
  parameter int UNIT_CYCLES = difl_pkg::DELAY_UNIT_CYCLES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // terminal pins
  input wire logic [difl_pkg::NUM_INPUTS-1:0] input_terminal,
  // terminal configuration
  input wire logic [7:0] input1_function_code,
  input wire logic [7:0] input2_function_code,
  input wire logic [7:0] input3_function_code,
  input wire logic [7:0] input4_function_code,
  input wire logic [7:0] input5_function_code,
  input wire logic [difl_pkg::NUM_INPUTS-1:0] input_polarity,
  // run command and frequency target
  input wire logic run_cmd,
  input wire logic [difl_pkg::FREQ_W-1:0] target_freq,
  input wire logic [difl_pkg::FREQ_W-1:0] motor_speed,
  // ramp settings
  input wire logic [difl_pkg::TIME_W-1:0] accel_time_first,
  input wire logic [difl_pkg::TIME_W-1:0] decel_time_first,
  input wire logic [difl_pkg::TIME_W-1:0] accel_time_second,
  input wire logic [difl_pkg::TIME_W-1:0] decel_time_second,
  input wire logic [1:0] ramp_switch_method,
  // coast restart settings
  input wire logic coast_restart_mode,
  input wire logic [difl_pkg::DELAY_W-1:0] coast_restart_delay,
  // outputs
  output logic output_enable,
  output logic [difl_pkg::FREQ_W-1:0] output_freq,
  output logic motor_bank_second,
  output logic ramp_stage_select,
  output logic [difl_pkg::TIME_W-1:0] active_ramp_time,
  output logic coast_active
);

  // function codes gathered for the generate loop
  logic [7:0] func_code [difl_pkg::NUM_INPUTS];
  assign func_code[0] = input1_function_code;
  assign func_code[1] = input2_function_code;
  assign func_code[2] = input3_function_code;
  assign func_code[3] = input4_function_code;
  assign func_code[4] = input5_function_code;

  // two-stage synchroniser on the raw pins
  logic [difl_pkg::NUM_INPUTS-1:0] sync_meta;
  logic [difl_pkg::NUM_INPUTS-1:0] sync_pin;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= '0;
      sync_pin <= '0;
    end else if (clk_en) begin
      sync_meta <= input_terminal;
      sync_pin <= sync_meta;
    end
  end

  // fill flags: the pin stages hold reset zeros for two edges
  logic [1:0] sync_fill;
  logic sync_ok;
  assign sync_ok = sync_fill[1];

  // zeros read as active on inverted terminals, so every function
  // stays masked until real pin levels reach the second stage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_fill <= 2'h0;
    end else if (clk_en) begin
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // active level per terminal after polarity
  logic [difl_pkg::NUM_INPUTS-1:0] term_active;
  logic [difl_pkg::NUM_INPUTS-1:0] hit_bank;
  logic [difl_pkg::NUM_INPUTS-1:0] hit_ramp;
  logic [difl_pkg::NUM_INPUTS-1:0] hit_coast;

  // decode of one terminal against one function
  function automatic logic func_hit(input logic [7:0] code,
                                    input logic [7:0] want,
                                    input logic act);
    func_hit = act && (code == want);
  endfunction

  // each terminal may carry any function
  genvar gi;
  generate
    for (gi = 0; gi < difl_pkg::NUM_INPUTS; gi++) begin : g_term
      // polarity high inverts to normally closed
      // masked until the synchroniser holds real pin levels
      assign term_active[gi] = sync_ok &&
          (sync_pin[gi] ^ input_polarity[gi]);
      assign hit_bank[gi] = func_hit(func_code[gi],
          difl_pkg::FUNC_BANK_SEL, term_active[gi]);
      assign hit_ramp[gi] = func_hit(func_code[gi],
          difl_pkg::FUNC_RAMP_STAGE, term_active[gi]);
      assign hit_coast[gi] = func_hit(func_code[gi],
          difl_pkg::FUNC_COAST_STOP, term_active[gi]);
    end
  endgenerate

  // any terminal asserting the function activates it
  logic bank_req;
  logic ramp_req;
  logic coast_req;
  assign bank_req = |hit_bank;
  // terminal ramp control only with method zero
  assign ramp_req = (|hit_ramp) &&
      (ramp_switch_method == difl_pkg::RAMP_METHOD_TERMINAL);
  assign coast_req = |hit_coast;

  // main control state
  // state type lives in the package
  difl_pkg::difl_state_t state;
  logic [difl_pkg::DELAY_W-1:0] delay_count;
  logic [31:0] unit_count;
  logic delay_done;
  assign delay_done = (delay_count == '0) &&
      (unit_count == 32'h0000_0000);

  // sequence: run, coast, wait, resume
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= difl_pkg::DIFL_STOPPED;
    end else if (clk_en) begin
      unique case (state)
        difl_pkg::DIFL_STOPPED: begin
          // no start until the pin levels are known
          if (sync_ok && run_cmd && !coast_req) begin
            state <= difl_pkg::DIFL_RUNNING;
          end
        end
        difl_pkg::DIFL_RUNNING: begin
          // coast wins over a stop request in the same cycle
          if (coast_req) begin
            state <= difl_pkg::DIFL_COASTING;
          end else if (!run_cmd && output_freq == difl_pkg::FREQ_ZERO) begin
            state <= difl_pkg::DIFL_STOPPED;
          end
        end
        difl_pkg::DIFL_COASTING: begin
          if (!coast_req) begin
            // resume only with run still held
            if (!run_cmd) begin
              state <= difl_pkg::DIFL_STOPPED;
            end else if (coast_restart_delay == '0) begin
              state <= difl_pkg::DIFL_RUNNING;
            end else begin
              state <= difl_pkg::DIFL_WAITING;
            end
          end
        end
        difl_pkg::DIFL_WAITING: begin
          // a fresh coast restarts the whole sequence
          if (coast_req) begin
            state <= difl_pkg::DIFL_COASTING;
          end else if (!run_cmd) begin
            state <= difl_pkg::DIFL_STOPPED;
          end else if (delay_done) begin
            state <= difl_pkg::DIFL_RUNNING;
          end
        end
      endcase
    end
  end

  // restart delay counter, in delay units
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      delay_count <= '0;
      unit_count <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state != difl_pkg::DIFL_WAITING) begin
        // preload so the full delay elapses in waiting
        // a zero delay never enters waiting, so the wrap is harmless
        delay_count <= coast_restart_delay - 8'h01;
        unit_count <= 32'(UNIT_CYCLES - 1);
      end else if (unit_count != 32'h0000_0000) begin
        unit_count <= unit_count - 32'h0000_0001;
      end else if (delay_count != '0) begin
        delay_count <= delay_count - 8'h01;
        unit_count <= 32'(UNIT_CYCLES - 1);
      end
    end
  end

  // bank select latched only while stopped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      motor_bank_second <= 1'b0;
    end else if (clk_en) begin
      if (state == difl_pkg::DIFL_STOPPED) begin
        // high means second bank, low main bank
        motor_bank_second <= bank_req;
      end else begin
        // any other state keeps the bank in use
        motor_bank_second <= motor_bank_second;
      end
    end
  end

  // ramp stage follows terminal at once, even mid-ramp
  // no hold-off here, unlike the bank select
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ramp_stage_select <= 1'b0;
    end else if (clk_en) begin
      ramp_stage_select <= ramp_req;
    end
  end

  // ramp direction and chosen time
  logic ramp_target_en;
  logic [difl_pkg::FREQ_W-1:0] ramp_goal;
  logic accelerating;
  logic [difl_pkg::TIME_W-1:0] next_ramp_time;
  assign ramp_target_en = (state == difl_pkg::DIFL_RUNNING) && run_cmd;
  assign ramp_goal = ramp_target_en ? target_freq : difl_pkg::FREQ_ZERO;
  assign accelerating = ramp_goal > output_freq;

  // time selection by stage and direction
  always_comb begin
    if (ramp_stage_select) begin
      next_ramp_time = accelerating ? accel_time_second
                                    : decel_time_second;
    end else begin
      next_ramp_time = accelerating ? accel_time_first
                                    : decel_time_first;
    end
  end

  // ramp tick prescaler; period set by ramp time
  logic [difl_pkg::TIME_W-1:0] tick_count;
  logic ramp_tick;
  assign ramp_tick = (tick_count >= active_ramp_time);

  // prescaler counts cycles between frequency steps
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_count <= '0;
      active_ramp_time <= '0;
    end else if (clk_en) begin
      // new time applies to the next step, mid-ramp
      active_ramp_time <= next_ramp_time;
      // a shorter time takes hold on the very next compare
      tick_count <= ramp_tick ? '0 : tick_count + 16'h0001;
    end
  end

  // output frequency and enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      output_freq <= difl_pkg::FREQ_ZERO;
      output_enable <= 1'b0;
      coast_active <= 1'b0;
    end else if (clk_en) begin
      // flag mirrors the coast state, not the pin
      coast_active <= (state == difl_pkg::DIFL_COASTING);
      unique case (state)
        difl_pkg::DIFL_STOPPED: begin
          // stopped always means off at zero
          output_enable <= 1'b0;
          output_freq <= difl_pkg::FREQ_ZERO;
        end
        difl_pkg::DIFL_COASTING, difl_pkg::DIFL_WAITING: begin
          // output off, motor coasts
          output_enable <= 1'b0;
          // restart point prepared for the resume
          output_freq <= (coast_restart_mode ==
              difl_pkg::RESTART_MATCH_SPEED) ? motor_speed
              : difl_pkg::FREQ_ZERO;
        end
        difl_pkg::DIFL_RUNNING: begin
          output_enable <= 1'b1;
          // one step per tick toward the goal; none once reached
          if (ramp_tick) begin
            if (accelerating) begin
              output_freq <= output_freq + difl_pkg::FREQ_STEP;
            end else if (ramp_goal < output_freq) begin
              output_freq <= output_freq - difl_pkg::FREQ_STEP;
            end
          end
        end
      endcase
    end
  end

endmodule

/* File: design/difl_pkg.sv */
package difl_pkg;
  // terminal count and function codes
  localparam int NUM_INPUTS = 5;
  localparam logic [7:0] FUNC_BANK_SEL = 8'h08;
  localparam logic [7:0] FUNC_RAMP_STAGE = 8'h09;
  localparam logic [7:0] FUNC_COAST_STOP = 8'h0B;
  // ramp switch method that enables terminal control
  localparam logic [1:0] RAMP_METHOD_TERMINAL = 2'h0;
  // restart modes after coast stop
  localparam logic RESTART_FROM_ZERO = 1'h0;
  localparam logic RESTART_MATCH_SPEED = 1'h1;
  // restart delay unit: 100 ms per count
  localparam int DELAY_UNIT_MS = 100;
  localparam int CLK_MHZ = 250;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * 1000 * CLK_MHZ;
  // widths
  localparam int TIME_W = 16;
  localparam int FREQ_W = 16;
  localparam int DELAY_W = 8;
  localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
  // frequency step applied on each ramp tick
  localparam logic [FREQ_W-1:0] FREQ_STEP = 16'h0001;
  typedef enum logic [1:0] {
    DIFL_STOPPED,
    DIFL_RUNNING,
    DIFL_COASTING,
    DIFL_WAITING
  } difl_state_t;
endpackage

/* File: dv/difl_term_ctrl.sv */
`timescale 1ns/1ps
// far side: terminal contacts plus the setup controller
module difl_term_ctrl (
  // clock
  input wire logic ref_clk,
  // requested contact levels and setup choice
  input wire logic [4:0] want,
  input wire logic alt_method,
  // terminal pins and ramp method
  output logic [4:0] pins,
  output logic [1:0] method
);
  // contacts move just after an edge, then hold as levels
  always_ff @(posedge ref_clk) begin
    pins <= want;
  end
  // terminal ramping needs method zero; alt models a misconfigured setup
  assign method = alt_method ? 2'h1 : difl_pkg::RAMP_METHOD_TERMINAL;
endmodule

/* File: dv/difl_drive_input_function_logic_assertions.sv */
`timescale 1ns/1ps
module difl_checker #(
  parameter int UNIT_CYCLES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // terminals and setup
  input wire logic [4:0] input_terminal,
  input wire logic [7:0] input1_function_code,
  input wire logic [7:0] input2_function_code,
  input wire logic [7:0] input3_function_code,
  input wire logic [7:0] input4_function_code,
  input wire logic [7:0] input5_function_code,
  input wire logic [4:0] input_polarity,
  input wire logic run_cmd,
  input wire logic [1:0] ramp_switch_method,
  input wire logic coast_restart_mode,
  input wire logic [7:0] coast_restart_delay,
  // outputs
  input wire logic output_enable,
  input wire logic [15:0] output_freq,
  input wire logic motor_bank_second,
  input wire logic ramp_stage_select,
  input wire logic coast_active
);
  logic [7:0] code [5]; // per-terminal function codes
  logic fb, fr, fc; // function levels seen at the raw pins
  // decode raw pins; sync delay is absorbed by repetition counts
  always_comb begin
    code = '{input1_function_code, input2_function_code,
             input3_function_code, input4_function_code,
             input5_function_code};
    fb = 1'b0;
    fr = 1'b0;
    fc = 1'b0;
    for (int i = 0; i < 5; i++) begin
      fb |= (input_terminal[i] ^ input_polarity[i])
            && code[i] == difl_pkg::FUNC_BANK_SEL;
      fr |= (input_terminal[i] ^ input_polarity[i])
            && code[i] == difl_pkg::FUNC_RAMP_STAGE;
      fc |= (input_terminal[i] ^ input_polarity[i])
            && code[i] == difl_pkg::FUNC_COAST_STOP;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn || !clk_en);
  property p_coast_off;
    fc [*6] |-> !output_enable && coast_active;
  endproperty
  a_coast_off: assert property (p_coast_off) else $error("coast no cut");
  property p_ramp_on;
    (fr && ramp_switch_method == 2'h0) [*6] |-> ramp_stage_select;
  endproperty
  a_ramp_on: assert property (p_ramp_on) else $error("ramp not set");
  property p_ramp_off;
    !fr [*6] |-> !ramp_stage_select;
  endproperty
  a_ramp_off: assert property (p_ramp_off) else $error("ramp stuck");
  property p_bank_hold;
    $changed(motor_bank_second) |-> !output_enable
      && output_freq == 16'h0000;
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank moved");
  property p_bank_set;
    (fb && !output_enable && !coast_active && !run_cmd
     && output_freq == 16'h0000) [*8] |-> motor_bank_second;
  endproperty
  a_bank_set: assert property (p_bank_set) else $error("bank not set");
  property p_bank_clr;
    (!fb && !output_enable && !coast_active && !run_cmd
     && output_freq == 16'h0000) [*8] |-> !motor_bank_second;
  endproperty
  a_bank_clr: assert property (p_bank_clr) else $error("bank stuck");
  property p_resume;
    $fell(coast_active) && run_cmd && coast_restart_delay == 8'h00
      |-> ##[1:8] output_enable;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_wait;
    $fell(coast_active) && run_cmd && coast_restart_delay != 8'h00
      |-> !output_enable [*4];
  endproperty
  a_wait: assert property (p_wait) else $error("resumed early");
  property p_from_zero;
    $rose(output_enable) && coast_restart_mode == 1'h0
      |-> $past(output_freq) == 16'h0000;
  endproperty
  a_from_zero: assert property (p_from_zero) else $error("not from 0");
  // main scenarios reached
  c_coast: cover property (fc ##1 !fc);
  c_bank: cover property ($rose(motor_bank_second));
  c_ramp: cover property ($rose(ramp_stage_select) && output_enable);
endmodule
bind difl_drive_input_function_logic difl_checker #(
  .UNIT_CYCLES(UNIT_CYCLES)
) u_chk (.ref_clk, .rstn, .clk_en, .input_terminal, .input1_function_code,
  .input2_function_code, .input3_function_code, .input4_function_code,
  .input5_function_code, .input_polarity, .run_cmd, .ramp_switch_method,
  .coast_restart_mode, .coast_restart_delay, .output_enable, .output_freq,
  .motor_bank_second, .ramp_stage_select, .coast_active);

/* File: dv/test_drive_input_function_logic.sv */
`timescale 1ns/1ps
module test_drive_input_function_logic;
  logic ref_clk = 1'b0; // 250 MHz
  logic rstn = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0; // hang guard
  logic [4:0] want = 5'h08; // terminal 4 idles high: active-low coast
  logic alt_method = 1'b0;
  logic [4:0] pins;
  logic [1:0] method;
  logic run_cmd = 1'b0;
  logic mode = 1'b0;
  logic [7:0] delay = 8'h00;
  logic en = 1'b1; // clock enable
  logic [4:0] pol = 5'h08; // terminal 4 inverted
  logic [7:0] code1 = difl_pkg::FUNC_BANK_SEL;
  logic [7:0] code2 = difl_pkg::FUNC_RAMP_STAGE;
  logic [7:0] code3 = difl_pkg::FUNC_COAST_STOP;
  logic [7:0] code4 = difl_pkg::FUNC_COAST_STOP;
  logic [7:0] code5 = difl_pkg::FUNC_RAMP_STAGE;
  logic [15:0] spd = 16'h0005; // motor speed seen by the drive
  logic [15:0] held; // value kept while the enable is low
  logic [15:0] last_freq; // restart point just before output returns
  logic oe, bank, ramp, coast;
  logic [15:0] freq, rtime;
  // pins, run, expected {bank, ramp, enable, coast}
  typedef struct packed {logic [4:0] p; logic r; logic [3:0] e;} difl_row_t;
  difl_row_t rows [10] = '{'{5'h08, 1'h0, 4'h0}, '{5'h09, 1'h0, 4'h8},
    '{5'h09, 1'h1, 4'hA}, '{5'h08, 1'h1, 4'hA}, '{5'h0A, 1'h1, 4'hE},
    '{5'h18, 1'h1, 4'hE}, '{5'h0C, 1'h1, 4'h9}, '{5'h08, 1'h1, 4'hA},
    '{5'h00, 1'h1, 4'h9}, '{5'h08, 1'h0, 4'h0}};
  always #2 ref_clk = ~ref_clk;
  difl_term_ctrl u_ctrl (.ref_clk(ref_clk), .want(want),
    .alt_method(alt_method), .pins(pins), .method(method));
  difl_drive_input_function_logic #(.UNIT_CYCLES(4)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(en), .input_terminal(pins),
    .input1_function_code(code1), .input2_function_code(code2),
    .input3_function_code(code3), .input4_function_code(code4),
    .input5_function_code(code5),
    .input_polarity(pol), .run_cmd(run_cmd), .target_freq(16'h0008),
    .motor_speed(spd), .accel_time_first(16'h0004),
    .decel_time_first(16'h0003), .accel_time_second(16'h0002),
    .decel_time_second(16'h0001), .ramp_switch_method(method),
    .coast_restart_mode(mode), .coast_restart_delay(delay),
    .output_enable(oe), .output_freq(freq), .motor_bank_second(bank),
    .ramp_stage_select(ramp), .active_ramp_time(rtime),
    .coast_active(coast));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // sample off the launching edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang; normal run is under 1000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    check({12'h0, bank, ramp, oe, coast}, 16'h0000);
    rstn <= 1'b1;
    // table of level cases, 60 cycles each to settle ramps
    foreach (rows[i]) begin
      @(posedge ref_clk);
      want <= rows[i].p;
      run_cmd <= rows[i].r;
      wait_cyc(60);
      check({12'h0, bank, ramp, oe, coast}, {12'h0, rows[i].e});
      $display("row %0d done", i);
    end
    // ramp switch mid-acceleration, then a refused method
    @(posedge ref_clk);
    run_cmd <= 1'b1;
    wait_cyc(8);
    check(rtime, 16'h0004);
    @(posedge ref_clk);
    want <= 5'h0A;
    wait_cyc(6);
    check(rtime, 16'h0002);
    check({15'h0, freq < 16'h0008}, 16'h0001);
    @(posedge ref_clk);
    alt_method <= 1'b1;
    wait_cyc(8);
    check({15'h0, ramp}, 16'h0000);
    @(posedge ref_clk);
    alt_method <= 1'b0;
    want <= 5'h08;
    mode <= 1'b1;
    delay <= 8'h03;
    $display("mid-ramp test done");
    // coast with delayed, speed-matched restart
    wait_cyc(30);
    @(posedge ref_clk);
    want <= 5'h0C;
    wait_cyc(12);
    check({15'h0, oe}, 16'h0000);
    @(posedge ref_clk);
    want <= 5'h08;
    wait_cyc(10);
    check({15'h0, oe}, 16'h0000);
    for (int k = 0; k < 40 && oe !== 1'b1; k++) begin
      last_freq = freq;
      wait_cyc(1);
    end
    check({15'h0, oe}, 16'h0001);
    check(last_freq, 16'h0005);
    $display("restart test done");
    // enable low must freeze the climbing ramp
    @(posedge ref_clk);
    en <= 1'b0;
    wait_cyc(1);
    held = freq;
    wait_cyc(12);
    check(freq, held);
    check({15'h0, oe}, 16'h0001);
    @(posedge ref_clk);
    en <= 1'b1;
    run_cmd <= 1'b0;
    $display("freeze test done");
    // stopped: add bank select on terminal 5 (terminal 1 keeps it), then invert terminal 5
    wait_cyc(60);
    check({15'h0, oe}, 16'h0000);
    @(posedge ref_clk);
    code5 <= difl_pkg::FUNC_BANK_SEL;
    want <= 5'h18;
    wait_cyc(8);
    check({15'h0, bank}, 16'h0001);
    @(posedge ref_clk);
    pol <= 5'h18;
    wait_cyc(8);
    check({15'h0, bank}, 16'h0000);
    @(posedge ref_clk);
    run_cmd <= 1'b1;
    wait_cyc(20);
    check({15'h0, oe}, 16'h0001);
    $display("reassign test done");
    // second reset in mid-run; inverted pins must not act at release
    @(posedge ref_clk);
    rstn <= 1'b0;
    wait_cyc(2);
    check({freq[11:0], bank, ramp, oe, coast}, 16'h0000);
    @(posedge ref_clk);
    rstn <= 1'b1;
    wait_cyc(2);
    check({freq[11:0], bank, ramp, oe, coast}, 16'h0000);
    wait_cyc(1);
    check({freq[11:0], bank, ramp, oe, coast}, 16'h0000);
    $display("reset test done");
    conclude();
  end
endmodule
